// ===== logic/ffc_pkg.sv
`default_nettype none
package ffc_pkg;
  localparam int NPIX = 64;
  localparam int NTAP = 2;
  localparam int IDXW = 6;
  localparam int PIXW = 12;
  localparam int FIFO_DEPTH = 4;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OFS_SET = 8'h04;
  localparam logic [7:0] REG_OFS_CAL = 8'h08;
  localparam logic [7:0] REG_OFS_TAP1 = 8'h0c;
  localparam logic [7:0] REG_OFS_TAP2 = 8'h10;
  localparam logic [7:0] REG_DIG_OFS = 8'h14;
  localparam logic [7:0] REG_BGND = 8'h18;
  localparam logic [7:0] REG_SYS_GAIN = 8'h1c;
  localparam logic [7:0] REG_WHITE_TGT = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam logic [7:0] REG_ANA_GAIN = 8'h28;
  localparam logic [7:0] REG_GAIN_REF = 8'h2c;
  localparam logic [7:0] REG_COEF_ADDR = 8'h30;
  localparam logic [7:0] REG_DARK_COEF = 8'h34;
  localparam logic [7:0] REG_GAIN_COEF = 8'h38;
  // control bits
  localparam int CTRL_OFS_CAL = 0;
  localparam int CTRL_DARK_CAL = 1;
  localparam int CTRL_WHITE_CAL = 2;
  localparam int CTRL_GAIN_REF = 3;
  localparam int CTRL_COEF_EN = 4;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_OFS_WARN = 1;
  localparam int ST_FIELD_WARN = 2;
  localparam int ST_CLIP_WARN = 3;
  localparam int ST_ORDER_ERR = 4;
  localparam int ST_DARK_VALID = 5;
  // field layout of offset commands
  localparam int TAP_LSB = 8;
  // values
  localparam logic [11:0] PIX_MAX = 12'hfff;
  localparam logic [10:0] DARK_MAX = 11'h7ff;
  localparam logic [11:0] DIG_OFS_MAX = 12'h800;
  localparam logic [11:0] GAIN_UNITY = 12'h200;
  localparam int GAIN_FRAC = 9;
  localparam logic [11:0] GAIN_MAX = 12'hfff;
  localparam logic [15:0] SYS_UNITY = 16'h1000;
  localparam int SYS_FRAC = 12;
  localparam logic [11:0] FIELD_MIN = 12'h010;
  localparam logic [6:0] CLIP_LIMIT = 7'h04;
  localparam logic [7:0] OFS_MAX = 8'hff;
  localparam logic [11:0] WHITE_TGT_RST = 12'hc00;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_OFS = 2'b01,
    CAL_DARK = 2'b11,
    CAL_WHITE = 2'b10
  } cal_state_t;

  typedef struct packed {
    logic [PIXW-1:0] data;
    logic tap;
    logic last;
  } pix_t;
endpackage : ffc_pkg
`default_nettype wire

// ===== logic/flat_field_offset_correction.sv
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

module px_fifo #(
  parameter int W = 12,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  localparam int CW = $clog2(D) + 1;
  logic [W-1:0] mem_q [D];
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic inReady_q;
  logic outValid_q;
  wire push = inValid && inReady_q;
  wire pop = outValid_q && outReady;
  assign count_d = count_q + CW'(push) - CW'(pop);
  assign inReady = inReady_q;
  assign outValid = outValid_q;
  assign outData = mem_q[0];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
      inReady_q <= 1'b1;
      outValid_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      inReady_q <= (count_d < CW'(D));
      outValid_q <= (count_d != '0);
    end
  end

  for (genvar i = 0; i < D; i++)
  begin : g_entry
    wire logic [W-1:0] nextUp;
    if (i < D - 1)
    begin : g_up
      assign nextUp = mem_q[i+1];
    end
    else
    begin : g_top
      assign nextUp = mem_q[i];
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        mem_q[i] <= '0;
      else if (pop)
        mem_q[i] <= (push && count_q == CW'(i + 1)) ? inData : nextUp;
      else if (push && count_q == CW'(i))
        mem_q[i] <= inData;
    end
  end
endmodule : px_fifo

// How it works
// - offset tap 0 means all, 1 or 2 one, 3 none
// - manual analog offset 0 to 255 applied
// - offset registers read back values in force
// - offset calibration steps toward tap average target
// - calibration target 1 to 255, same taps
// - unreachable low target raises warning flag
// - gain reference update copies present analog gains
// - out = ((in-dark-ofs)*gain - bg) * sysgain
// - dark run stores per pixel dark coefficient
// - white run computes per pixel gain multiplier
// - white run refused until dark done
// - dim field pixels raise field warning
// - gain coefficient clipped at eight to one
// - clipped share of row raises warning
// - dark run clears digital offset
// - white run forces bg 0, unity, coef off
module flat_field_offset_correction
  import ffc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire ffc_pkg::pix_t pixIn,
  input wire logic pixValid,
  output logic pixReady,
  output logic [ffc_pkg::PIXW-1:0] pixOut,
  output logic outValid,
  input wire logic outReady,
  output logic [1:0][7:0] anaOffset,
  output logic [1:0][7:0] gainRef
);
  import ffc_pkg::*;

  cal_state_t state_q;
  logic [10:0] darkMem_q [NPIX];
  logic [11:0] gainMem_q [NPIX];
  logic [IDXW-1:0] pixIdx_q;
  logic [IDXW-1:0] coefAddr_q;
  logic [11:0] digOfs_q;
  logic [11:0] bgnd_q;
  logic [15:0] sysGain_q;
  logic [11:0] whiteTgt_q;
  logic coefEn_q;
  logic [1:0] calSel_q;
  logic [7:0] calTgt_q;
  logic [1:0] tapDone_q;
  logic inLine_q;
  logic [6:0] clipCnt_q;
  logic ofsWarn_q, fieldWarn_q, clipWarn_q, orderErr_q, darkValid_q;
  logic [1:0][7:0] anaGain_q;
  logic [31:0] regRdata_q;
  logic [1:0] tapOfsWarn;

  // register decode
  wire wrCtrl = regWr && regAddr == REG_CTRL;
  wire wrOfsSet = regWr && regAddr == REG_OFS_SET;
  wire wrStatus = regWr && regAddr == REG_STATUS;
  wire [1:0] wTap = regWdata[TAP_LSB+1:TAP_LSB];
  wire [1:0] setSel = (wTap == 2'd0) ? 2'b11 : (wTap == 2'd1) ? 2'b01 :
                      (wTap == 2'd2) ? 2'b10 : 2'b00;
  wire idle = state_q == CAL_IDLE;
  wire startOfs = regWr && regAddr == REG_OFS_CAL && idle && regWdata[7:0] != 8'h00
                  && setSel != 2'b00;
  wire startDark = wrCtrl && regWdata[CTRL_DARK_CAL] && idle;
  wire startWhite = wrCtrl && regWdata[CTRL_WHITE_CAL] && idle && darkValid_q;
  wire whiteRefuse = wrCtrl && regWdata[CTRL_WHITE_CAL] && idle && !darkValid_q;

  // pixel accept and line position
  wire accept = pixValid && pixReady;
  wire active = !idle && (inLine_q || pixIdx_q == '0);
  wire lineEnd = accept && active && pixIn.last;
  wire tap = pixIn.tap;

  // datapath
  wire coefUse = coefEn_q && state_q != CAL_WHITE;
  wire [10:0] darkUse = coefUse ? darkMem_q[pixIdx_q] : 11'h000;
  wire [11:0] gainUse = coefUse ? gainMem_q[pixIdx_q] : GAIN_UNITY;
  wire [11:0] bgEff = (state_q == CAL_WHITE) ? 12'h000 : bgnd_q;
  wire [15:0] sysEff = (state_q == CAL_WHITE) ? SYS_UNITY : sysGain_q;
  wire signed [14:0] diff1 = $signed({3'b000, pixIn.data}) - $signed({4'h0, darkUse})
                             - $signed({3'b000, digOfs_q});
  wire [11:0] stage1 = diff1[14] ? 12'h000 : (diff1 > 15'sd4095 ? PIX_MAX : diff1[11:0]);
  wire [23:0] prod2 = stage1 * gainUse;
  wire [14:0] shr2 = prod2[23:GAIN_FRAC];
  wire [11:0] stage2 = (shr2 > 15'(PIX_MAX)) ? PIX_MAX : shr2[11:0];
  wire [11:0] stage3 = (stage2 > bgEff) ? stage2 - bgEff : 12'h000;
  wire [27:0] prod4 = stage3 * sysEff;
  wire [15:0] shr4 = prod4[27:SYS_FRAC];
  wire [11:0] corrected = (shr4 > 16'(PIX_MAX)) ? PIX_MAX : shr4[11:0];

  // white calibration arithmetic
  wire [11:0] darkNow = {1'b0, darkMem_q[pixIdx_q]};
  wire [11:0] litLevel = (pixIn.data > darkNow) ? pixIn.data - darkNow : 12'h000;
  wire [20:0] quot = (litLevel == 12'h000) ? 21'h1fffff
                     : ({whiteTgt_q, 9'h000} / {9'h000, litLevel});
  wire coefClip = quot > 21'(GAIN_MAX);
  wire [11:0] whiteCoef = coefClip ? GAIN_MAX : quot[11:0];
  wire [10:0] darkCap = (pixIn.data > 12'(DARK_MAX)) ? DARK_MAX : pixIn.data[10:0];
  wire [6:0] clipNext = clipCnt_q + 7'(coefClip);

  px_fifo #(.W(PIXW), .D(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .inValid(pixValid),
    .inData(corrected),
    .inReady(pixReady),
    .outValid(outValid),
    .outData(pixOut),
    .outReady(outReady)
  );

  // per tap offset, calibration and gain reference
  for (genvar t = 0; t < NTAP; t++)
  begin : g_tap
    logic [17:0] sum_q;
    logic [5:0] cnt_q;
    logic [7:0] ofs_q;
    wire hit = accept && active && state_q == CAL_OFS && tap == 1'(t);
    wire [17:0] sumAll = sum_q + (hit ? 18'(pixIn.data) : 18'h0);
    wire [5:0] cntAll = cnt_q + 6'(hit);
    wire [17:0] avg = (cntAll == '0) ? 18'h0 : sumAll / {12'h000, cntAll};
    wire stepHere = lineEnd && state_q == CAL_OFS && calSel_q[t] && !tapDone_q[t];
    wire over = avg > 18'(calTgt_q);
    wire under = avg < 18'(calTgt_q);
    assign tapOfsWarn[t] = stepHere && over && ofs_q == 8'h00;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        sum_q <= '0;
        cnt_q <= '0;
        ofs_q <= '0;
        tapDone_q[t] <= 1'b1;
        gainRef[t] <= '0;
      end
      else
      begin
        sum_q <= lineEnd || idle ? 18'h0 : sumAll;
        cnt_q <= lineEnd || idle ? 6'h0 : cntAll;
        if (wrOfsSet && idle && setSel[t])
          ofs_q <= regWdata[7:0];
        else if (stepHere && over && ofs_q != 8'h00)
          ofs_q <= ofs_q - 8'h01;
        else if (stepHere && under && ofs_q != OFS_MAX)
          ofs_q <= ofs_q + 8'h01;
        if (startOfs)
          tapDone_q[t] <= !setSel[t];
        else if (stepHere && (!(over || under) || tapOfsWarn[t] || (under && ofs_q == OFS_MAX)))
          tapDone_q[t] <= 1'b1;
        if (wrCtrl && regWdata[CTRL_GAIN_REF])
          gainRef[t] <= anaGain_q[t];
      end
    end
    assign anaOffset[t] = ofs_q;
  end

  // coefficient memories
  always_ff @(posedge core_clk)
  begin
    if (accept && active && state_q == CAL_DARK)
      darkMem_q[pixIdx_q] <= darkCap;
    else if (regWr && regAddr == REG_DARK_COEF && idle)
      darkMem_q[coefAddr_q] <= regWdata[10:0];
    if (accept && active && state_q == CAL_WHITE)
      gainMem_q[pixIdx_q] <= whiteCoef;
    else if (regWr && regAddr == REG_GAIN_COEF && idle)
      gainMem_q[coefAddr_q] <= regWdata[11:0];
  end

  // sequencing and settings
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= CAL_IDLE;
      pixIdx_q <= '0;
      inLine_q <= 1'b0;
      calSel_q <= '0;
      calTgt_q <= '0;
      clipCnt_q <= '0;
      coefEn_q <= 1'b0;
      coefAddr_q <= '0;
      digOfs_q <= '0;
      bgnd_q <= '0;
      sysGain_q <= SYS_UNITY;
      whiteTgt_q <= WHITE_TGT_RST;
      anaGain_q <= '0;
    end
    else
    begin
      if (accept)
        pixIdx_q <= pixIn.last ? '0 : pixIdx_q + IDXW'(1);
      inLine_q <= !idle && !lineEnd && (inLine_q || (accept && pixIdx_q == '0));
      case (state_q)
        CAL_IDLE:
        begin
          clipCnt_q <= '0;
          if (startOfs)
          begin
            state_q <= CAL_OFS;
            calSel_q <= setSel;
            calTgt_q <= regWdata[7:0];
          end
          else if (startDark)
            state_q <= CAL_DARK;
          else if (startWhite)
            state_q <= CAL_WHITE;
        end
        CAL_OFS:
          if (tapDone_q == 2'b11)
            state_q <= CAL_IDLE;
        CAL_DARK:
          if (lineEnd)
            state_q <= CAL_IDLE;
        CAL_WHITE:
        begin
          if (accept && active)
            clipCnt_q <= clipNext;
          if (lineEnd)
            state_q <= CAL_IDLE;
        end
        default:
          state_q <= CAL_IDLE;
      endcase
      if (wrCtrl)
        coefEn_q <= regWdata[CTRL_COEF_EN];
      if (regWr && regAddr == REG_COEF_ADDR)
        coefAddr_q <= regWdata[IDXW-1:0];
      if (state_q == CAL_DARK && lineEnd)
        digOfs_q <= '0;
      else if (regWr && regAddr == REG_DIG_OFS)
        digOfs_q <= (regWdata[11:0] > DIG_OFS_MAX) ? DIG_OFS_MAX : regWdata[11:0];
      if (regWr && regAddr == REG_BGND)
        bgnd_q <= regWdata[11:0];
      if (regWr && regAddr == REG_SYS_GAIN)
        sysGain_q <= regWdata[15:0];
      if (regWr && regAddr == REG_WHITE_TGT)
        whiteTgt_q <= regWdata[11:0];
      if (regWr && regAddr == REG_ANA_GAIN)
        anaGain_q <= regWdata[15:0];
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ofsWarn_q <= 1'b0;
      fieldWarn_q <= 1'b0;
      clipWarn_q <= 1'b0;
      orderErr_q <= 1'b0;
      darkValid_q <= 1'b0;
    end
    else
    begin
      ofsWarn_q <= (tapOfsWarn != 2'b00)
                   || (ofsWarn_q && !(wrStatus && regWdata[ST_OFS_WARN]));
      fieldWarn_q <= (state_q == CAL_WHITE && accept && active && litLevel < FIELD_MIN)
                     || (fieldWarn_q && !(wrStatus && regWdata[ST_FIELD_WARN]));
      clipWarn_q <= (state_q == CAL_WHITE && lineEnd && clipNext >= CLIP_LIMIT)
                    || (clipWarn_q && !(wrStatus && regWdata[ST_CLIP_WARN]));
      orderErr_q <= whiteRefuse
                    || (orderErr_q && !(wrStatus && regWdata[ST_ORDER_ERR]));
      if (state_q == CAL_DARK && lineEnd)
        darkValid_q <= 1'b1;
    end
  end

  // read back
  wire [31:0] statusWord = {26'h0, darkValid_q, orderErr_q, clipWarn_q, fieldWarn_q,
                            ofsWarn_q, !idle};
  logic [31:0] rdMux;
  always_comb
  begin
    if (regAddr == REG_CTRL)
      rdMux = {27'h0, coefEn_q, 4'h0};
    else if (regAddr == REG_OFS_TAP1)
      rdMux = {24'h0, anaOffset[0]};
    else if (regAddr == REG_OFS_TAP2)
      rdMux = {24'h0, anaOffset[1]};
    else if (regAddr == REG_OFS_CAL)
      rdMux = {22'h0, calSel_q, calTgt_q};
    else if (regAddr == REG_DIG_OFS)
      rdMux = {20'h0, digOfs_q};
    else if (regAddr == REG_BGND)
      rdMux = {20'h0, bgnd_q};
    else if (regAddr == REG_SYS_GAIN)
      rdMux = {16'h0, sysGain_q};
    else if (regAddr == REG_WHITE_TGT)
      rdMux = {20'h0, whiteTgt_q};
    else if (regAddr == REG_STATUS)
      rdMux = statusWord;
    else if (regAddr == REG_ANA_GAIN)
      rdMux = {16'h0, anaGain_q};
    else if (regAddr == REG_GAIN_REF)
      rdMux = {16'h0, gainRef};
    else if (regAddr == REG_COEF_ADDR)
      rdMux = {26'h0, coefAddr_q};
    else if (regAddr == REG_DARK_COEF)
      rdMux = {21'h0, darkMem_q[coefAddr_q]};
    else if (regAddr == REG_GAIN_COEF)
      rdMux = {20'h0, gainMem_q[coefAddr_q]};
    else
      rdMux = 32'h0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata_q <= '0;
    else
      regRdata_q <= regRd ? rdMux : 32'h0;
  end
  assign regRdata = regRdata_q;

  a_ofs_all_taps: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrOfsSet && idle && wTap == 2'd0 |=> anaOffset[0] == anaOffset[1])
    else $error("tap 0 did not set both offsets");
  a_ofs_one_tap: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrOfsSet && idle && wTap == 2'd2 |=> anaOffset[1] == $past(regWdata[7:0])
      && $stable(anaOffset[0]))
    else $error("single tap offset wrong");
  a_ofs_query: assert property (@(posedge core_clk) disable iff (!rst_n)
    regRd && regAddr == REG_OFS_TAP1 |=> regRdata == {24'h0, $past(anaOffset[0])})
    else $error("offset query wrong");
  a_cal_zero_tgt: assert property (@(posedge core_clk) disable iff (!rst_n)
    regWr && regAddr == REG_OFS_CAL && idle && regWdata[7:0] == 8'h00 |=> state_q == CAL_IDLE)
    else $error("target 0 started calibration");
  a_gain_ref_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrCtrl && regWdata[CTRL_GAIN_REF] |=> gainRef == $past(anaGain_q))
    else $error("gain reference not copied");
  a_white_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    whiteRefuse |=> state_q == CAL_IDLE && orderErr_q)
    else $error("white run without dark data");
  a_dark_ofs_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == CAL_DARK && lineEnd |=> digOfs_q == 12'h000 && state_q == CAL_IDLE)
    else $error("digital offset not cleared");
  a_white_unity: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == CAL_WHITE && accept && digOfs_q == 12'h000 |-> corrected == pixIn.data)
    else $error("white run settings not forced");
  a_floor_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && pixIn.data <= digOfs_q |-> corrected == 12'h000)
    else $error("dark pixel did not floor at zero");
  a_coef_clip: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && active && state_q == CAL_WHITE
      && {3'b000, whiteTgt_q, 9'h000} >= {litLevel, 12'h000} |-> whiteCoef == GAIN_MAX)
    else $error("gain coefficient not clipped");
endmodule : flat_field_offset_correction

`default_nettype wire

// ===== tb/line_host.sv
`timescale 1ns/10ps
`default_nettype none
module line_host
  import ffc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [6:0] len,
  input wire logic addOfs,
  input wire logic [1:0] stall,
  input wire logic [1:0][7:0] anaOffset,
  input wire logic pixReady,
  output var ffc_pkg::pix_t pixIn,
  output logic pixValid,
  input wire logic [ffc_pkg::PIXW-1:0] pixOut,
  input wire logic outValid,
  output logic outReady,
  output logic [6:0] nGot
);
  logic [11:0] pattern [64];
  logic [11:0] got [64];
  logic [6:0] idx;
  logic [1:0] cnt;
  logic [12:0] sum;
  // sensor level plus analog offset, clipped at full scale
  assign sum = {1'b0, pattern[idx[5:0]]} + (addOfs ? {5'h00, anaOffset[idx[0]]} : 13'h0000);
  // stall 0 prompt, 1 one cycle in four, 2 blocked
  assign outReady = (stall == 2'h0) || (stall == 2'h1 && cnt == 2'h0);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      idx <= 7'h00;
      cnt <= 2'h0;
      nGot <= 7'h00;
      pixValid <= 1'b0;
      pixIn <= '0;
    end
    else
    begin
      cnt <= cnt + 2'h1;
      if (go)
      begin
        idx <= 7'h00;
        nGot <= 7'h00;
      end
      else
      begin
        if (!pixValid || pixReady)
        begin
          if (idx < len)
          begin
            pixValid <= 1'b1;
            pixIn.data <= sum[12] ? 12'hfff : sum[11:0];
            pixIn.tap <= idx[0];
            pixIn.last <= (idx == len - 7'h01);
            idx <= idx + 7'h01;
          end
          else
          begin
            pixValid <= 1'b0;
            pixIn.data <= ~pixIn.data;
          end
        end
        if (outValid && outReady)
        begin
          got[nGot[5:0]] <= pixOut;
          nGot <= nGot + 7'h01;
        end
      end
    end
endmodule : line_host
`default_nettype wire

// ===== tb/flat_field_offset_correction_bench.sv
`timescale 1ns/10ps
`default_nettype none
module flat_field_offset_correction_bench;
  import ffc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  pix_t pixIn;
  logic pixValid, pixReady, outValid, outReady;
  logic [PIXW-1:0] pixOut;
  logic [1:0][7:0] anaOffset, gainRef;
  logic go = 1'b0;
  logic [6:0] len = 7'h00;
  logic addOfs = 1'b0;
  logic [1:0] stall = 2'h0;
  logic [6:0] nGot;
  int fails = 0;
  int total_checks = 0;
  int n;
  logic [31:0] v;

  always #2 core_clk = ~core_clk;

  flat_field_offset_correction i_flat_field_offset_correction (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pixIn(pixIn),
    .pixValid(pixValid), .pixReady(pixReady), .pixOut(pixOut), .outValid(outValid),
    .outReady(outReady), .anaOffset(anaOffset), .gainRef(gainRef));
  line_host i_line_host (
    .clk(core_clk), .rst_n(rst_n), .go(go), .len(len), .addOfs(addOfs), .stall(stall),
    .anaOffset(anaOffset), .pixReady(pixReady), .pixIn(pixIn), .pixValid(pixValid),
    .pixOut(pixOut), .outValid(outValid), .outReady(outReady), .nGot(nGot));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    v = regRdata;
    @(posedge core_clk);
    if (nm != "") chk(nm, e, v);
  endtask : rdc
  task automatic start(input logic [6:0] l, input logic [1:0] s);
    stall <= s;
    len <= l;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
  endtask : start
  task automatic finish(input logic [6:0] l);
    int t;
    t = 0;
    @(posedge core_clk);
    while (nGot !== l && t < 2000)
    begin
      @(posedge core_clk);
      t++;
    end
    if (t >= 2000) chk("line done", 32'h1, 32'h0);
  endtask : finish
  task automatic line(input logic [6:0] l, input logic [1:0] s);
    start(l, s);
    finish(l);
  endtask : line
  task automatic cal;
    n = 0;
    do
    begin
      line(7'd64, 2'h0);
      n++;
      rdc("", REG_STATUS, 32'h0);
    end while (v[0] !== 1'b0 && n < 80);
    if (n >= 80) chk("cal busy", 32'h0, 32'h1);
  endtask : cal
  task automatic px(input logic [11:0] i, input logic [11:0] e);
    i_line_host.pattern[0] = i;
    line(7'd1, 2'h0);
    chk("pixOut", e, i_line_host.got[0]);
  endtask : px

  task automatic t_reset;
    chk("pixReady", 32'h1, pixReady);
    chk("outValid", 32'h0, outValid);
    chk("anaOffset", 32'h0, anaOffset);
    chk("gainRef", 32'h0, gainRef);
    rdc("sysGain", REG_SYS_GAIN, SYS_UNITY);
    rdc("whiteTgt", REG_WHITE_TGT, WHITE_TGT_RST);
    rdc("unmapped", 8'hfc, 32'h0);
  endtask : t_reset
  task automatic t_order;
    wr(REG_CTRL, 32'h04);
    rdc("status", REG_STATUS, 32'h10);
    wr(REG_STATUS, 32'h10);
    rdc("status", REG_STATUS, 32'h0);
  endtask : t_order
  task automatic t_offset;
    addOfs <= 1'b1;
    for (int k = 0; k < 64; k++) i_line_host.pattern[k] = 12'h014;
    wr(REG_OFS_SET, 32'h023);
    wr(REG_OFS_SET, 32'h240);
    rdc("ofsTap1", REG_OFS_TAP1, 32'h23);
    rdc("ofsTap2", REG_OFS_TAP2, 32'h40);
    chk("anaOffset", 32'h4023, anaOffset);
    wr(REG_OFS_CAL, 32'h000);
    rdc("status", REG_STATUS, 32'h0);
    wr(REG_OFS_CAL, 32'h032);
    cal;
    chk("anaOffset", 32'h1e1e, anaOffset);
    wr(REG_OFS_CAL, 32'h10a);
    cal;
    chk("anaOffset", 32'h1e00, anaOffset);
    rdc("status", REG_STATUS, 32'h02);
    wr(REG_STATUS, 32'h1e);
    rdc("status", REG_STATUS, 32'h0);
    addOfs <= 1'b0;
  endtask : t_offset
  task automatic t_gainref;
    wr(REG_ANA_GAIN, 32'h1234);
    wr(REG_CTRL, 32'h08);
    wr(REG_ANA_GAIN, 32'h5678);
    rdc("status", REG_STATUS, 32'h0);
    chk("gainRef", 32'h1234, gainRef);
  endtask : t_gainref
  task automatic t_path;
    wr(REG_DIG_OFS, 32'h64);
    wr(REG_SYS_GAIN, 32'h2000);
    px(12'h258, 12'h3e8);
    px(12'h032, 12'h000);
    px(12'hfa0, 12'hfff);
    for (int k = 0; k < 8; k++) i_line_host.pattern[k] = 12'(200 + 100 * k);
    start(7'd8, 2'h2);
    repeat (20) @(posedge core_clk);
    chk("pixReady full", 32'h0, pixReady);
    chk("outValid held", 32'h1, outValid);
    stall <= 2'h1;
    finish(7'd8);
    for (int k = 0; k < 8; k++) chk("fifo out", 200 * k + 200, i_line_host.got[k]);
    wr(REG_COEF_ADDR, 32'h0);
    wr(REG_DARK_COEF, 32'ha);
    wr(REG_GAIN_COEF, 32'h400);
    wr(REG_BGND, 32'h32);
    wr(REG_SYS_GAIN, 32'h1000);
    wr(REG_CTRL, 32'h10);
    px(12'h0d2, 12'h096);
    px(12'hbb8, 12'hfcd);
  endtask : t_path
  task automatic t_dark;
    wr(REG_DIG_OFS, 32'h64);
    for (int k = 0; k < 64; k++) i_line_host.pattern[k] = 12'(5 + k);
    wr(REG_CTRL, 32'h02);
    cal;
    chk("dark lines", 32'h1, n);
    rdc("digOfs", REG_DIG_OFS, 32'h0);
    rdc("status", REG_STATUS, 32'h20);
  endtask : t_dark
  task automatic t_white;
    int lit;
    int g;
    for (int k = 0; k < 64; k++)
      i_line_host.pattern[k] = 12'(5 + k + (k < 4 ? 100 : k == 4 ? 5 : 1000 + 8 * k));
    wr(REG_WHITE_TGT, 32'h800);
    wr(REG_BGND, 32'h64);
    wr(REG_SYS_GAIN, 32'h2000);
    wr(REG_CTRL, 32'h14);
    cal;
    chk("white lines", 32'h1, n);
    for (int k = 0; k < 64; k++)
      chk("white run", i_line_host.pattern[k], i_line_host.got[k]);
    rdc("status", REG_STATUS, 32'h2c);
    rdc("ctrl", REG_CTRL, 32'h10);
    wr(REG_BGND, 32'h0);
    wr(REG_SYS_GAIN, 32'h1000);
    line(7'd64, 2'h1);
    for (int k = 0; k < 64; k++)
    begin
      lit = i_line_host.pattern[k] - 5 - k;
      g = (2048 * 512) / lit;
      g = g > 4095 ? 4095 : g;
      g = (lit * g) / 512;
      chk("flat out", g > 4095 ? 4095 : g, i_line_host.got[k]);
    end
    for (int k = 0; k < 64; k++) i_line_host.pattern[k] = 12'(5 + k);
    line(7'd64, 2'h0);
    for (int k = 0; k < 64; k++) chk("dark flat", 32'h0, i_line_host.got[k]);
  endtask : t_white

  task automatic final_report;
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_order;
    t_offset;
    t_gainref;
    t_path;
    t_dark;
    t_white;
    final_report;
  end
  initial
  begin
    #240000;
    fails++;
    final_report;
  end
endmodule : flat_field_offset_correction_bench
`default_nettype wire
